/* File: rtl/rtcal_top.v */
`timescale 1ns/1ps
`include "rtcal_defs.vh"
// Contract
// [R1] arm clears after last alarm without chime
// [R2] chime wraps counter, else holds at zero
// [R3] interval mask bits 13-10 choose period
// [R4] yearly feb 29 alarm only leap years
// [R5] software avoids reserved interval codes
// [R6] pointer bits 9-8 select alarm pair
// [R7] high-byte access decrements pointer, stops zero
// [R8] counter bits 7-0 count further alarms
// [R9] each alarm event decrements a nonzero repeat counter
// [R10] year holds two bcd digits, upper zero
// [R11] value writes need unlock bit set
// [R12] month digits read-only in time register
// [R13] weekday/hour bcd field layout
// [R14] minute/second bcd layout, bits 15,7 zero
// [R15] alarm month/day all fields writable
// [R16] time window writes blocked when locked
// [R17] any alarm window read decrements pointer
// [R18] mask decides which digits must match
// [R19] interrupt request on every alarm event
// [R20] compare per half-second tick, one-cycle event
module rtcal_top (
	clk_sys,
	nrst,
	half_sec_tick,
	second_half,
	month_load,
	month_load_value,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_byteenable,
	avs_readdata,
	avs_waitrequest,
	alarm_irq,
	alarm_arm_out
);
	input wire clk_sys;
	input wire nrst;
	input wire half_sec_tick;
	input wire second_half;
	input wire month_load;
	input wire [4:0] month_load_value;
	input wire [3:0] avs_address;
	input wire avs_read;
	input wire avs_write;
	input wire [31:0] avs_writedata;
	input wire [3:0] avs_byteenable;
	output reg [31:0] avs_readdata;
	output reg avs_waitrequest;
	output reg alarm_irq;
	output reg alarm_arm_out;

	reg [15:0] cfg_reg;
	reg [15:0] year_reg;
	reg [15:0] month_day_value_reg;
	reg [15:0] wkhr_reg;
	reg [15:0] minute_second_value_reg;
	reg [15:0] al_ms_reg;
	reg [15:0] al_wh_reg;
	reg [15:0] al_md_reg;
	reg unlock_reg;
	reg [15:0] cfg_next;
	reg [15:0] rdata_next;
	reg [15:0] wmask;
	reg [15:0] wdat;
	reg acc;
	reg alarm_event;
	wire hit;
	wire wr;
	wire rd;
	wire hi_lane;
	wire [3:0] interval_mask;
	wire [1:0] alarm_window_pointer;
	wire [7:0] repeat_counter;
	wire arm;
	wire chime;
	wire rd_take;
	wire val_wr;
	wire sel_cfg;
	wire sel_alwin;
	wire sel_year;
	wire sel_month_day_value;
	wire sel_wkhr;
	wire sel_minute_second_value;
	wire sel_ctrl;
	wire sel_stat;

	assign interval_mask = cfg_reg[`RTCAL_MSK_HI:`RTCAL_MSK_LO]; // [R3]
	assign alarm_window_pointer = cfg_reg[`RTCAL_PTR_HI:`RTCAL_PTR_LO]; // [R6]
	assign repeat_counter = cfg_reg[`RTCAL_RPT_HI:0]; // [R8]
	assign arm = cfg_reg[`RTCAL_ARM];
	assign chime = cfg_reg[`RTCAL_CHIME];
	// read data latched at the first edge; writes and pointer steps
	// land at the second edge, where waitrequest is seen low
	assign wr = avs_write && acc;
	assign rd = avs_read && acc;
	assign rd_take = avs_read && !acc;
	assign hi_lane = avs_byteenable[1];

	// address decode, one comparator per register
	rtcal_digit_eq #(.W(4)) u_sel_cfg (
		.a(avs_address),
		.b(`RTCAL_A_CFG),
		.mask(`RTCAL_A_MASK),
		.eq(sel_cfg)
	);
	rtcal_digit_eq #(.W(4)) u_sel_alwin (
		.a(avs_address),
		.b(`RTCAL_A_ALWIN),
		.mask(`RTCAL_A_MASK),
		.eq(sel_alwin)
	);
	rtcal_digit_eq #(.W(4)) u_sel_year (
		.a(avs_address),
		.b(`RTCAL_A_YEAR),
		.mask(`RTCAL_A_MASK),
		.eq(sel_year)
	);
	rtcal_digit_eq #(.W(4)) u_sel_month_day_value (
		.a(avs_address),
		.b(`RTCAL_A_MONTH_DAY_VALUE),
		.mask(`RTCAL_A_MASK),
		.eq(sel_month_day_value)
	);
	rtcal_digit_eq #(.W(4)) u_sel_wkhr (
		.a(avs_address),
		.b(`RTCAL_A_WKHR),
		.mask(`RTCAL_A_MASK),
		.eq(sel_wkhr)
	);
	rtcal_digit_eq #(.W(4)) u_sel_minute_second_value (
		.a(avs_address),
		.b(`RTCAL_A_MINUTE_SECOND_VALUE),
		.mask(`RTCAL_A_MASK),
		.eq(sel_minute_second_value)
	);
	rtcal_digit_eq #(.W(4)) u_sel_ctrl (
		.a(avs_address),
		.b(`RTCAL_A_CTRL),
		.mask(`RTCAL_A_MASK),
		.eq(sel_ctrl)
	);
	rtcal_digit_eq #(.W(4)) u_sel_stat (
		.a(avs_address),
		.b(`RTCAL_A_STAT),
		.mask(`RTCAL_A_MASK),
		.eq(sel_stat)
	);

	// byte-lane write mask on the low 16 bits
	always @* begin
		wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
		wdat = avs_writedata[15:0];
	end

	rtcal_match u_match (
		.interval_mask(interval_mask),
		.second_half(second_half),
		.t_ms(minute_second_value_reg),
		.t_wh(wkhr_reg),
		.t_md(month_day_value_reg),
		.t_year(year_reg[7:0]),
		.a_ms(al_ms_reg),
		.a_wh(al_wh_reg),
		.a_md(al_md_reg),
		.hit(hit)
	);

	// alarm event pulse, evaluated on each tick while armed
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			alarm_event <= 1'b0;
			alarm_irq <= 1'b0;
		end else begin
			alarm_event <= half_sec_tick && arm && hit; // [R20] [R18]
			alarm_irq <= half_sec_tick && arm && hit; // [R19]
		end
	end

	// configuration next value: software write, pointer, alarm event
	always @* begin
		cfg_next = cfg_reg;
		if (wr && sel_cfg)
			cfg_next = (cfg_reg & ~wmask) | (wdat & wmask);
		if ((wr && sel_alwin && hi_lane) ||
			(rd && sel_alwin)) begin // [R17]
			if (alarm_window_pointer != `RTCAL_PTR_MS)
				cfg_next[`RTCAL_PTR_HI:`RTCAL_PTR_LO] =
					alarm_window_pointer - `RTCAL_PTR_ONE; // [R7]
		end
		if (alarm_event) begin
			if (repeat_counter != `RTCAL_ZERO8)
				cfg_next[`RTCAL_RPT_HI:0] = repeat_counter - 8'h01; // [R9]
			else if (chime)
				cfg_next[`RTCAL_RPT_HI:0] = `RTCAL_ONES8; // [R2]
			else
				cfg_next[`RTCAL_ARM] = 1'b0; // [R1]
		end
	end

	// writes to value and alarm registers need the unlock bit
	assign val_wr = wr && unlock_reg; // [R11] [R16]

	// configuration word: bus writes, pointer steps, alarm updates
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cfg_reg <= `RTCAL_ZERO16;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	// value write unlock lives in bit 0 of the control word
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			unlock_reg <= 1'b0;
		end else if (wr && sel_ctrl && avs_byteenable[0]) begin
			unlock_reg <= avs_writedata[0];
		end
	end

	// year: two bcd digits, upper byte never written
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			year_reg <= `RTCAL_ZERO16;
		end else if (val_wr && sel_year) begin
			year_reg <= (year_reg & ~wmask) |
				(wdat & wmask & `RTCAL_YEAR_MASK); // [R10]
		end
	end

	// month digits come only from the timekeeping side
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			month_day_value_reg <= `RTCAL_ZERO16;
		end else begin
			if (month_load)
				month_day_value_reg[12:8] <= month_load_value;
			if (val_wr && sel_month_day_value)
				month_day_value_reg[7:0] <= (month_day_value_reg[7:0] & ~wmask[7:0]) |
					(wdat[7:0] & wmask[7:0] & `RTCAL_DAY_MASK8); // [R12]
		end
	end

	// weekday and hour digits
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wkhr_reg <= `RTCAL_ZERO16;
		end else if (val_wr && sel_wkhr) begin
			wkhr_reg <= (wkhr_reg & ~wmask) |
				(wdat & wmask & `RTCAL_WH_MASK); // [R13]
		end
	end

	// minute and second digits, spare bits kept zero
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			minute_second_value_reg <= `RTCAL_ZERO16;
		end else if (val_wr && sel_minute_second_value) begin
			minute_second_value_reg <= (minute_second_value_reg & ~wmask) |
				(wdat & wmask & `RTCAL_MS_MASK); // [R14]
		end
	end

	// alarm minute/second pair behind pointer code 00
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			al_ms_reg <= `RTCAL_ZERO16;
		end else if (val_wr && sel_alwin &&
			alarm_window_pointer == `RTCAL_PTR_MS) begin // [R6]
			al_ms_reg <= (al_ms_reg & ~wmask) |
				(wdat & wmask & `RTCAL_MS_MASK);
		end
	end

	// alarm weekday/hour pair behind pointer code 01
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			al_wh_reg <= `RTCAL_ZERO16;
		end else if (val_wr && sel_alwin &&
			alarm_window_pointer == `RTCAL_PTR_WH) begin // [R6]
			al_wh_reg <= (al_wh_reg & ~wmask) |
				(wdat & wmask & `RTCAL_WH_MASK);
		end
	end

	// alarm month/day pair behind pointer code 10, all digits writable
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			al_md_reg <= `RTCAL_ZERO16;
		end else if (val_wr && sel_alwin &&
			alarm_window_pointer == `RTCAL_PTR_MD) begin // [R6]
			al_md_reg <= (al_md_reg & ~wmask) |
				(wdat & wmask & `RTCAL_MD_MASK); // [R15]
		end
	end

	// read multiplexer; unmapped addresses read zero
	always @* begin
		case (avs_address)
			`RTCAL_A_CFG: rdata_next = cfg_reg;
			`RTCAL_A_ALWIN: begin
				case (alarm_window_pointer) // [R6]
					`RTCAL_PTR_MS: rdata_next = al_ms_reg;
					`RTCAL_PTR_WH: rdata_next = al_wh_reg;
					`RTCAL_PTR_MD: rdata_next = al_md_reg;
					default: rdata_next = `RTCAL_ZERO16;
				endcase
			end
			`RTCAL_A_YEAR: rdata_next = year_reg;
			`RTCAL_A_MONTH_DAY_VALUE: rdata_next = month_day_value_reg;
			`RTCAL_A_WKHR: rdata_next = wkhr_reg;
			`RTCAL_A_MINUTE_SECOND_VALUE: rdata_next = minute_second_value_reg;
			`RTCAL_A_CTRL: rdata_next = {15'h0000, unlock_reg};
			`RTCAL_A_STAT: rdata_next = {15'h0000, arm};
			default: rdata_next = `RTCAL_ZERO16;
		endcase
	end

	// bus handshake: waitrequest high until the answer cycle
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			acc <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0000_0000;
		end else begin
			acc <= (avs_read || avs_write) && !acc;
			avs_waitrequest <= !((avs_read || avs_write) && !acc);
			if (rd_take)
				avs_readdata <= {16'h0000, rdata_next};
		end
	end

	// arm bit on its own pin, in step with the configuration word
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			alarm_arm_out <= 1'b0;
		end else begin
			alarm_arm_out <= cfg_next[`RTCAL_ARM];
		end
	end
endmodule

/* File: rtl/rtcal_defs.vh */
`ifndef RTCAL_DEFS_VH
`define RTCAL_DEFS_VH
// register word addresses
`define RTCAL_A_CFG 4'h0
`define RTCAL_A_ALWIN 4'h1
`define RTCAL_A_YEAR 4'h2
`define RTCAL_A_MONTH_DAY_VALUE 4'h3
`define RTCAL_A_WKHR 4'h4
`define RTCAL_A_MINUTE_SECOND_VALUE 4'h5
`define RTCAL_A_CTRL 4'h6
`define RTCAL_A_STAT 4'h7
// alarm configuration fields
`define RTCAL_ARM 15
`define RTCAL_CHIME 14
`define RTCAL_MSK_HI 13
`define RTCAL_MSK_LO 10
`define RTCAL_PTR_HI 9
`define RTCAL_PTR_LO 8
`define RTCAL_RPT_HI 7
// writable masks and widths
`define RTCAL_CFG_MASK 16'hffff
`define RTCAL_YEAR_MASK 16'h00ff
`define RTCAL_MD_MASK 16'h1f3f
`define RTCAL_DAY_MASK 16'h003f
`define RTCAL_DAY_MASK8 8'h3f
`define RTCAL_A_MASK 4'hf
`define RTCAL_WH_MASK 16'h073f
`define RTCAL_MS_MASK 16'h7f7f
`define RTCAL_ZERO16 16'h0000
`define RTCAL_ZERO8 8'h00
`define RTCAL_ONES8 8'hff
// window pointer codes
`define RTCAL_PTR_MS 2'h0
`define RTCAL_PTR_WH 2'h1
`define RTCAL_PTR_MD 2'h2
`define RTCAL_PTR_ONE 2'h1
// interval mask codes
`define RTCAL_M_HALF 4'h0
`define RTCAL_M_SEC 4'h1
`define RTCAL_M_10S 4'h2
`define RTCAL_M_MIN 4'h3
`define RTCAL_M_10M 4'h4
`define RTCAL_M_HOUR 4'h5
`define RTCAL_M_DAY 4'h6
`define RTCAL_M_WEEK 4'h7
`define RTCAL_M_MONTH 4'h8
`define RTCAL_M_YEAR 4'h9
// february 29th in bcd month/day layout
`define RTCAL_FEB29 16'h0229
`define RTCAL_LEAP_MOD 2'h0
`endif

/* File: rtl/rtcal_digit_eq.v */
`timescale 1ns/1ps
// compares the masked bits of two words, one or more fields
module rtcal_digit_eq #(
	parameter W = 16
) (
	a,
	b,
	mask,
	eq
);
	input wire [W-1:0] a;
	input wire [W-1:0] b;
	input wire [W-1:0] mask;
	output wire eq;
	// equal when every masked bit agrees
	assign eq = ((a ^ b) & mask) == {W{1'b0}};
endmodule

/* File: rtl/rtcal_match.v */
`timescale 1ns/1ps
`include "rtcal_defs.vh"
// decides from the interval mask whether the alarm digits match
module rtcal_match (
	input wire [3:0] interval_mask,
	input wire second_half,
	input wire [15:0] t_ms,
	input wire [15:0] t_wh,
	input wire [15:0] t_md,
	input wire [7:0] t_year,
	input wire [15:0] a_ms,
	input wire [15:0] a_wh,
	input wire [15:0] a_md,
	output reg hit
);
	wire sec1_eq;
	wire sec_eq;
	wire min1_eq;
	wire min_eq;
	wire hr_eq;
	wire wd_eq;
	wire day_eq;
	wire md_eq;
	wire leap_ok;
	rtcal_digit_eq #(.W(16)) u_s1 (.a(t_ms), .b(a_ms), .mask(16'h000f),
		.eq(sec1_eq));
	rtcal_digit_eq #(.W(16)) u_s (.a(t_ms), .b(a_ms), .mask(16'h007f),
		.eq(sec_eq));
	rtcal_digit_eq #(.W(16)) u_m1 (.a(t_ms), .b(a_ms), .mask(16'h0f7f),
		.eq(min1_eq));
	rtcal_digit_eq #(.W(16)) u_m (.a(t_ms), .b(a_ms),
		.mask(`RTCAL_MS_MASK), .eq(min_eq));
	rtcal_digit_eq #(.W(16)) u_h (.a(t_wh), .b(a_wh), .mask(16'h003f),
		.eq(hr_eq));
	rtcal_digit_eq #(.W(16)) u_w (.a(t_wh), .b(a_wh), .mask(16'h0700),
		.eq(wd_eq));
	rtcal_digit_eq #(.W(16)) u_d (.a(t_md), .b(a_md),
		.mask(`RTCAL_DAY_MASK), .eq(day_eq));
	rtcal_digit_eq #(.W(16)) u_md (.a(t_md), .b(a_md),
		.mask(`RTCAL_MD_MASK), .eq(md_eq));
	// bcd year divisible by four: even tens needs ones 0,4,8
	assign leap_ok = (t_year[4] ? (t_year[1:0] == 2'b10) :
		(t_year[1:0] == `RTCAL_LEAP_MOD)) && !t_year[0];
	// digit selection per interval code
	always @* begin
		case (interval_mask)
			`RTCAL_M_HALF: hit = 1'b1;
			`RTCAL_M_SEC: hit = !second_half;
			`RTCAL_M_10S: hit = !second_half && sec1_eq;
			`RTCAL_M_MIN: hit = !second_half && sec_eq;
			`RTCAL_M_10M: hit = !second_half && min1_eq;
			`RTCAL_M_HOUR: hit = !second_half && min_eq;
			`RTCAL_M_DAY: hit = !second_half && min_eq && hr_eq;
			`RTCAL_M_WEEK: hit = !second_half && min_eq && hr_eq && wd_eq;
			`RTCAL_M_MONTH: hit = !second_half && min_eq && hr_eq && day_eq;
			`RTCAL_M_YEAR: hit = !second_half && min_eq && hr_eq && md_eq &&
				((a_md & `RTCAL_MD_MASK) != `RTCAL_FEB29 || leap_ok); // [R4]
			default: hit = 1'b0;
		endcase
	end
endmodule

/* File: sim/rtcal_chk_sva.sv */
`timescale 1ns/1ps
`include "rtcal_defs.vh"
// port-level checks of the alarm and value registers
module rtcal_chk (
	input wire clk_sys,
	input wire nrst,
	input wire half_sec_tick,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire alarm_irq,
	input wire alarm_arm_out
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// read answered in this cycle
	wire rv = !avs_waitrequest && avs_read;
	AST_IRQ_ONE: assert property (alarm_irq |=> !alarm_irq)
		else $error("irq wider than one cycle");
	AST_IRQ_CAUSE: assert property (alarm_irq |->
		$past(half_sec_tick) && $past(alarm_arm_out))
		else $error("irq without armed tick");
	AST_ARM_FALL: assert property ($fell(alarm_arm_out) |-> $past(alarm_irq)
		|| $past(avs_write) || $past(avs_write, 2))
		else $error("arm dropped without cause");
	AST_ACK: assert property ((avs_read || avs_write)
		&& !$past(avs_read || avs_write) |=> !avs_waitrequest)
		else $error("request not answered");
	AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer longer than one cycle");
	AST_TOP_ZERO: assert property (rv |-> avs_readdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	AST_YEAR: assert property (rv && avs_address == `RTCAL_A_YEAR
		|-> avs_readdata[15:8] == 8'h00)
		else $error("year upper byte not zero");
	AST_MD: assert property (rv && avs_address == `RTCAL_A_MONTH_DAY_VALUE
		|-> avs_readdata[15:13] == 3'h0 && avs_readdata[7:6] == 2'h0)
		else $error("month/day spare bits set");
	AST_WH: assert property (rv && avs_address == `RTCAL_A_WKHR
		|-> avs_readdata[15:11] == 5'h00 && avs_readdata[7:6] == 2'h0)
		else $error("weekday/hour spare bits set");
	AST_MS: assert property (rv && avs_address == `RTCAL_A_MINUTE_SECOND_VALUE
		|-> !avs_readdata[15] && !avs_readdata[7])
		else $error("minute/second spare bits set");
endmodule
bind rtcal_top rtcal_chk u_chk (.clk_sys(clk_sys), .nrst(nrst),
	.half_sec_tick(half_sec_tick), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.alarm_irq(alarm_irq), .alarm_arm_out(alarm_arm_out));

/* File: sim/rtcal_tb.sv */
`timescale 1ns/1ps
`include "rtcal_defs.vh"
module testbench;
	reg clk_sys, nrst, half_sec_tick, second_half, month_load;
	reg [4:0] month_load_value;
	reg [3:0] avs_address, avs_byteenable;
	reg avs_read, avs_write;
	reg [31:0] avs_writedata;
	wire [31:0] avs_readdata;
	wire avs_waitrequest, alarm_irq, alarm_arm_out;
	integer num_errors, checks_done, i;
	reg [15:0] q;
	rtcal_top uut (.clk_sys(clk_sys), .nrst(nrst),
		.half_sec_tick(half_sec_tick), .second_half(second_half),
		.month_load(month_load), .month_load_value(month_load_value),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .alarm_irq(alarm_irq),
		.alarm_arm_out(alarm_arm_out));
	initial begin
		clk_sys = 0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task print_verdict;
		begin
			if (num_errors == 0 && checks_done > 0)
				$display("TB: PASS");
			else
				$display("TB: FAIL");
			$finish;
		end
	endtask
	task chk(input [15:0] g, input [15:0] e);
		begin
			checks_done = checks_done + 1;
			if (g !== e) begin
				num_errors = num_errors + 1;
				$display("unexpected at %0t: got %h want %h", $time, g, e);
			end
		end
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task bus(input w, input [3:0] a, input [15:0] d, input [3:0] be);
		integer n;
		begin
			@(posedge clk_sys);
			avs_read <= !w;
			avs_write <= w;
			avs_address <= a;
			avs_writedata <= {16'h0000, d};
			avs_byteenable <= be;
			n = 0;
			do begin
				@(posedge clk_sys);
				n = n + 1;
			end while (avs_waitrequest !== 1'b0 && n < 20);
			q = avs_readdata[15:0];
			avs_read <= 0;
			avs_write <= 0;
			if (n >= 20) begin
				num_errors = num_errors + 1;
				$display("unexpected at %0t: bus answer timed out", $time);
				print_verdict;
			end
		end
	endtask
	task wr(input [3:0] a, input [15:0] d);
		bus(1, a, d, 4'h3);
	endtask
	task rd(input [3:0] a, input [15:0] e);
		begin
			bus(0, a, 16'h0000, 4'h3);
			chk(q, e);
		end
	endtask
	// one half-second tick, irq looked at in its single cycle
	task tick(input e);
		begin
			@(posedge clk_sys);
			half_sec_tick <= 1;
			@(posedge clk_sys);
			half_sec_tick <= 0;
			#1 chk({15'h0000, alarm_irq}, {15'h0000, e});
			@(posedge clk_sys);
		end
	endtask
	task mload(input [4:0] v);
		begin
			@(posedge clk_sys);
			month_load <= 1;
			month_load_value <= v;
			@(posedge clk_sys);
			month_load <= 0;
		end
	endtask
	task t_reset;
		begin
			rd(`RTCAL_A_CFG, 16'h0000);
			rd(`RTCAL_A_STAT, 16'h0000);
			rd(4'h8, 16'h0000);
		end
	endtask
	task t_values;
		begin
			wr(`RTCAL_A_YEAR, 16'h0012);
			rd(`RTCAL_A_YEAR, 16'h0000);
			wr(`RTCAL_A_CTRL, 16'h0001);
			wr(`RTCAL_A_YEAR, 16'hff99);
			rd(`RTCAL_A_YEAR, 16'h0099);
			wr(`RTCAL_A_MONTH_DAY_VALUE, 16'hffff);
			rd(`RTCAL_A_MONTH_DAY_VALUE, 16'h003f);
			mload(5'h12);
			rd(`RTCAL_A_MONTH_DAY_VALUE, 16'h123f);
			wr(`RTCAL_A_WKHR, 16'hffff);
			rd(`RTCAL_A_WKHR, 16'h073f);
			wr(`RTCAL_A_MINUTE_SECOND_VALUE, 16'hffff);
			rd(`RTCAL_A_MINUTE_SECOND_VALUE, 16'h7f7f);
			wr(`RTCAL_A_CTRL, 16'h0000);
			wr(`RTCAL_A_MINUTE_SECOND_VALUE, 16'h0000);
			rd(`RTCAL_A_MINUTE_SECOND_VALUE, 16'h7f7f);
			wr(`RTCAL_A_CTRL, 16'h0001);
		end
	endtask
	task t_window;
		begin
			wr(`RTCAL_A_CFG, 16'h0200);
			wr(`RTCAL_A_ALWIN, 16'hffff);
			rd(`RTCAL_A_CFG, 16'h0100);
			bus(1, `RTCAL_A_ALWIN, 16'h003f, 4'h1);
			rd(`RTCAL_A_CFG, 16'h0100);
			wr(`RTCAL_A_ALWIN, 16'hffff);
			wr(`RTCAL_A_ALWIN, 16'hffff);
			rd(`RTCAL_A_CFG, 16'h0000);
			wr(`RTCAL_A_CFG, 16'h0200);
			rd(`RTCAL_A_ALWIN, 16'h1f3f);
			rd(`RTCAL_A_CFG, 16'h0100);
			rd(`RTCAL_A_ALWIN, 16'h073f);
			rd(`RTCAL_A_ALWIN, 16'h7f7f);
			rd(`RTCAL_A_ALWIN, 16'h7f7f);
		end
	endtask
	task t_repeat;
		begin
			wr(`RTCAL_A_CFG, 16'h8002);
			rd(`RTCAL_A_STAT, 16'h0001);
			tick(1);
			rd(`RTCAL_A_CFG, 16'h8001);
			tick(1);
			tick(1);
			rd(`RTCAL_A_CFG, 16'h0000);
			chk({15'h0000, alarm_arm_out}, 16'h0000);
			tick(0);
			wr(`RTCAL_A_CFG, 16'hc000);
			tick(1);
			rd(`RTCAL_A_CFG, 16'hc0ff);
		end
	endtask
	task t_masks;
		begin
			for (i = 1; i < 10; i = i + 1) begin
				wr(`RTCAL_A_CFG, 16'h8000 | (i << 10));
				second_half <= 1;
				tick(0);
				second_half <= 0;
				tick(i < 9);
			end
		end
	endtask
	task t_leap;
		begin
			wr(`RTCAL_A_CFG, 16'h0200);
			wr(`RTCAL_A_ALWIN, 16'h0229);
			mload(5'h02);
			wr(`RTCAL_A_MONTH_DAY_VALUE, 16'h0029);
			wr(`RTCAL_A_YEAR, 16'h0001);
			wr(`RTCAL_A_CFG, 16'ha400);
			tick(0);
			wr(`RTCAL_A_YEAR, 16'h0004);
			tick(1);
		end
	endtask
	initial begin
		num_errors = 0;
		checks_done = 0;
		nrst = 0;
		half_sec_tick = 0;
		second_half = 0;
		month_load = 0;
		month_load_value = 5'h00;
		avs_address = 4'h0;
		avs_byteenable = 4'h0;
		avs_read = 0;
		avs_write = 0;
		avs_writedata = 32'h0000_0000;
		repeat (16) @(posedge clk_sys);
		nrst <= 1;
		t_reset;
		t_values;
		t_window;
		t_repeat;
		t_masks;
		t_leap;
		print_verdict;
	end
endmodule
